/* File: rtl/conv_seq_pkg.sv */
package conv_seq_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int RES_W  = 10;
  localparam int CHAN_W = 3;
  localparam int IRQ_W  = 3;
  localparam int CNT_W  = 8;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL1    = 16'h7032;
  localparam logic [ADDR_W-1:0] OFS_CTRL2    = 16'h7034;
  localparam logic [ADDR_W-1:0] OFS_FIFO_A   = 16'h7036;
  localparam logic [ADDR_W-1:0] OFS_FIFO_B   = 16'h7038;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 16'h703a;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 16'h703c;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int C2_SW_START = 0;
  localparam int C2_EXT_EN   = 1;
  localparam int C2_TMR_EN   = 2;
  localparam int IRQ_EOC     = 0;
  localparam int IRQ_OVF     = 1;
  localparam int IRQ_TMO     = 2;
  localparam logic [DATA_W-1:0] CTRL1_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] CTRL1_WMASK = 16'h0fff;
  localparam logic [IRQ_W-1:0]  MASK_RST    = 3'h0;
  localparam logic [1:0]        FIFO_FULL   = 2'h2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_MAX_NS   = 1000;
  localparam int PAIR_NS       = 1700;
  localparam int CONV_MAX_CYC  = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int PAIR_CYC      = (PAIR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] TMO_LIMIT  = CNT_W'(CONV_MAX_CYC);
  localparam logic [CNT_W-1:0] PAIR_LIMIT = CNT_W'(PAIR_CYC);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_CONV_A = 2'b01,
    ST_CONV_B = 2'b10,
    ST_GAP    = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic [3:0]        rsvd;
    logic [3:0]        prescale;
    logic              immediate;
    logic              continuous;
    logic [CHAN_W-1:0] chan_b;
    logic [CHAN_W-1:0] chan_a;
  } ctrl1_t;

  typedef struct packed {
    logic              start;
    logic              clk_en;
    logic [CHAN_W-1:0] chan;
  } core_req_t;

  typedef struct packed {
    logic             done;
    logic [RES_W-1:0] result;
  } core_rsp_t;

  typedef struct packed {
    logic [1:0]       cnt;
    logic [RES_W-1:0] m1;
    logic [RES_W-1:0] m0;
  } fifo_t;
endpackage : conv_seq_pkg

/* File: rtl/dual_result_conversion_sequencer.sv */
`timescale 1ns/1ps
// How it works
// R1 - Single mode runs one pair per request; continuous mode repeats pairs unasked.
// R2 - Continuous pairs start one pair period apart, counted in prescaled ticks.
// R3 - Each pseudo converter owns a result FIFO two entries deep.
// R4 - A push into a full FIFO drops the oldest entry and flags overflow.
// R5 - Starts come from a software write, pin transitions or timer events.
// R6 - Control register 1 is written freely; a working copy feeds the sequencer.
// R7 - Immediate bit chooses restart now or hold request until pair ends.
// R8 - Single mode sets end flag per pair; irq only when unmasked.
// R9 - One request runs converter A then converter B back to back.
// R10 - Each pseudo converter has a three-bit channel select for eight inputs.
// R11 - Results are ten-bit codes, 1024 steps across the reference span.
// R12 - Results land in the FIFO of the pseudo converter that made them.
// R13 - Working copy reloads only when idle, between pairs or on restart.
// R14 - A conversion not done within one microsecond of ticks is aborted.
// R15 - Drive start and channel to core, latch result on done, then push.
module dual_result_conversion_sequencer (
  // Clock, reset, enable
  input  wire logic                              i_mclk,
  input  wire logic                              i_rstn,
  input  wire logic                              i_ce,
  // Register port
  input  wire logic [conv_seq_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [conv_seq_pkg::DATA_W-1:0]   i_wdata,
  input  wire logic                              i_wr,
  input  wire logic                              i_rd,
  output logic      [conv_seq_pkg::DATA_W-1:0]   o_rdata,
  // Start sources
  input  wire logic                              i_ext_start_pin,
  input  wire logic                              i_timer_trig,
  // Converter core
  output conv_seq_pkg::core_req_t                o_core,
  input  wire conv_seq_pkg::core_rsp_t           i_core,
  // Interrupt
  output logic                                   o_periph_irq
);
  import conv_seq_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic                ext_s1_r;
  logic                ext_s2_r;
  logic                ext_s3_r;
  ctrl1_t              ctrl1_r;
  ctrl1_t              act_r;
  logic                ext_en_r;
  logic                tmr_en_r;
  logic [IRQ_W-1:0]    stat_r;
  logic [IRQ_W-1:0]    mask_r;
  seq_state_t          state_r;
  seq_state_t          state_nxt;
  logic                pend_r;
  logic [3:0]          presc_cnt_r;
  logic [CNT_W-1:0]    tmo_cnt_r;
  logic [CNT_W-1:0]    gap_cnt_r;
  fifo_t               fifo_r [2];
  logic                push_a_r;
  logic                push_b_r;
  logic [RES_W-1:0]    res_r;
  core_req_t           core_r;
  logic [DATA_W-1:0]   rdata_r;
  logic [DATA_W-1:0]   rdata_nxt;
  logic                irq_r;
  logic                go_a;
  logic                go_b;
  logic                pair_go;

  // ----------------------------------------
  // FIFO step: pop first, then push
  // ----------------------------------------
  // Full push shifts out the oldest so the newest two always survive
  function automatic fifo_t fifo_step(input fifo_t f, input logic push,
                                      input logic pop, input logic [RES_W-1:0] d);
    fifo_t n;
    n = f;
    if (pop && (f.cnt != 2'h0)) begin
      n.m0  = f.m1;
      n.cnt = f.cnt - 2'h1;
    end
    if (push) begin
      if (n.cnt == 2'h0) begin
        n.m0 = d;
      end else if (n.cnt == 2'h1) begin
        n.m1 = d;
      end else begin
        n.m0 = n.m1; // R4
        n.m1 = d;
      end
      if (n.cnt != FIFO_FULL) begin
        n.cnt = n.cnt + 2'h1;
      end
    end
    return n;
  endfunction : fifo_step

  // ----------------------------------------
  // Start pin synchroniser
  // ----------------------------------------
  // Third flop only feeds the edge detector; first flop is left alone
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else if (i_ce) begin
      ext_s1_r <= i_ext_start_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // ----------------------------------------
  // Address decode and strobes
  // ----------------------------------------
  wire sel_c1 = (i_addr == OFS_CTRL1);
  wire sel_c2 = (i_addr == OFS_CTRL2);
  wire sel_fa = (i_addr == OFS_FIFO_A);
  wire sel_fb = (i_addr == OFS_FIFO_B);
  wire sel_st = (i_addr == OFS_IRQ_STAT);
  wire sel_mk = (i_addr == OFS_IRQ_MASK);
  wire wr_c1  = i_wr & sel_c1;
  wire wr_c2  = i_wr & sel_c2;
  wire wr_st  = i_wr & sel_st;
  wire wr_mk  = i_wr & sel_mk;
  wire pop_a  = i_rd & sel_fa;
  wire pop_b  = i_rd & sel_fb;

  // ----------------------------------------
  // Trigger sources and sequencing terms
  // ----------------------------------------
  // Any pin transition counts, rising or falling
  wire ext_edge = ext_s2_r ^ ext_s3_r;
  wire sw_start = wr_c2 & i_wdata[C2_SW_START];
  wire trig     = sw_start | (ext_en_r & ext_edge) | (tmr_en_r & i_timer_trig); // R5
  wire busy     = (state_r != ST_IDLE);
  wire in_conv  = (state_r == ST_CONV_A) | (state_r == ST_CONV_B);
  // Immediate bit is not shadowed: it decides how this very request lands
  wire restart  = trig & busy & ctrl1_r.immediate; // R7
  wire core_done = i_core.done & in_conv;
  wire tick     = (presc_cnt_r == act_r.prescale);
  // Next pair fires on the tick that completes the period, not one tick later
  wire gap_done = tick & (gap_cnt_r >= PAIR_LIMIT - 8'h01); // R2
  wire tmo_hit  = in_conv & (tmo_cnt_r == TMO_LIMIT) & ~core_done & ~restart; // R14
  wire pair_end = (state_r == ST_CONV_B) & core_done & ~restart;
  // Working copy may reload only outside a conversion or on a restart
  wire apply    = (state_r == ST_IDLE) | (state_r == ST_GAP) | pair_end | restart; // R13
  wire ctrl1_t cfg = apply ? ctrl1_r : act_r; // R6

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    go_a      = 1'b0;
    go_b      = 1'b0;
    pair_go   = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (trig || pend_r) begin
          state_nxt = ST_CONV_A; // R1
          go_a      = 1'b1;
          pair_go   = 1'b1;
        end
      end
      ST_CONV_A: begin
        if (restart) begin
          go_a = 1'b1;
        end else if (core_done) begin
          state_nxt = ST_CONV_B; // R9
          go_b      = 1'b1;
        end else if (tmo_hit) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_CONV_B: begin
        if (restart) begin
          state_nxt = ST_CONV_A;
          go_a      = 1'b1;
        end else if (pair_end) begin
          if (cfg.continuous) begin
            state_nxt = ST_GAP; // R1
          end else if (trig || pend_r) begin
            state_nxt = ST_CONV_A;
            go_a      = 1'b1;
            pair_go   = 1'b1;
          end else begin
            state_nxt = ST_IDLE;
          end
        end else if (tmo_hit) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_GAP: begin
        if (restart) begin
          state_nxt = ST_CONV_A;
          go_a      = 1'b1;
        end else if (!cfg.continuous) begin
          state_nxt = ST_IDLE;
        end else if (gap_done) begin
          state_nxt = ST_CONV_A; // R2
          go_a      = 1'b1;
          pair_go   = 1'b1;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Sequencer registers
  // ----------------------------------------
  // A deferred request is held until a pair actually begins
  wire pend_nxt = (pend_r | (trig & busy & ~ctrl1_r.immediate)) & ~pair_go; // R7
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= ST_IDLE;
      pend_r  <= 1'b0;
      act_r   <= ctrl1_t'(CTRL1_RST);
    end else if (i_ce) begin
      state_r <= state_nxt;
      pend_r  <= pend_nxt;
      act_r   <= cfg; // R13
    end
  end

  // Prescaler, timeout and pair period counters
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      presc_cnt_r <= 4'h0;
      tmo_cnt_r   <= '0;
      gap_cnt_r   <= '0;
    end else if (i_ce) begin
      presc_cnt_r <= tick ? 4'h0 : presc_cnt_r + 4'h1;
      if (go_a || go_b) begin
        tmo_cnt_r <= '0;
      end else if (in_conv && tick && (tmo_cnt_r != TMO_LIMIT)) begin
        tmo_cnt_r <= tmo_cnt_r + 8'h01; // R14
      end
      if (go_a) begin
        gap_cnt_r <= '0;
      end else if (tick && (gap_cnt_r != PAIR_LIMIT)) begin
        gap_cnt_r <= gap_cnt_r + 8'h01; // R2
      end
    end
  end

  // ----------------------------------------
  // Converter core request and result latch
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      core_r   <= '0;
      res_r    <= '0;
      push_a_r <= 1'b0;
      push_b_r <= 1'b0;
    end else if (i_ce) begin
      core_r.start  <= go_a | go_b; // R15
      core_r.clk_en <= tick;
      if (go_b) begin
        core_r.chan <= cfg.chan_b; // R10
      end else if (go_a) begin
        core_r.chan <= cfg.chan_a; // R10
      end
      if (go_b || pair_end) begin
        res_r <= i_core.result; // R11
      end
      push_a_r <= go_b;     // R12
      push_b_r <= pair_end; // R12
    end
  end

  // ----------------------------------------
  // Result FIFOs
  // ----------------------------------------
  fifo_t fa_nxt;
  fifo_t fb_nxt;
  assign fa_nxt = fifo_step(fifo_r[0], push_a_r, pop_a, res_r); // R3
  assign fb_nxt = fifo_step(fifo_r[1], push_b_r, pop_b, res_r); // R3
  wire ovf_a = push_a_r & ~pop_a & (fifo_r[0].cnt == FIFO_FULL); // R4
  wire ovf_b = push_b_r & ~pop_b & (fifo_r[1].cnt == FIFO_FULL); // R4
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      fifo_r[0] <= '0;
      fifo_r[1] <= '0;
    end else if (i_ce) begin
      fifo_r[0] <= fa_nxt;
      fifo_r[1] <= fb_nxt;
    end
  end

  // ----------------------------------------
  // Control, status and mask registers
  // ----------------------------------------
  // Set beats a same-cycle write-one clear
  wire [IRQ_W-1:0] ev = {tmo_hit, ovf_a | ovf_b, pair_end & ~cfg.continuous}; // R8
  wire [IRQ_W-1:0] st_clr = wr_st ? i_wdata[IRQ_W-1:0] : 3'h0;
  wire [IRQ_W-1:0] stat_nxt = (stat_r & ~st_clr) | ev;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl1_r  <= ctrl1_t'(CTRL1_RST);
      ext_en_r <= 1'b0;
      tmr_en_r <= 1'b0;
      stat_r   <= '0;
      mask_r   <= MASK_RST;
      irq_r    <= 1'b0;
    end else if (i_ce) begin
      if (wr_c1) begin
        ctrl1_r <= ctrl1_t'(i_wdata & CTRL1_WMASK); // R6
      end
      if (wr_c2) begin
        ext_en_r <= i_wdata[C2_EXT_EN];
        tmr_en_r <= i_wdata[C2_TMR_EN];
      end
      if (wr_mk) begin
        mask_r <= i_wdata[IRQ_W-1:0];
      end
      stat_r <= stat_nxt;
      irq_r  <= |(stat_r & mask_r); // R8
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Empty FIFO reads as zero and pops nothing
  always_comb begin
    rdata_nxt = 16'h0000;
    if (sel_c1) begin
      rdata_nxt = ctrl1_r;
    end else if (sel_c2) begin
      rdata_nxt = {8'h00, fifo_r[1].cnt, fifo_r[0].cnt, busy, tmr_en_r, ext_en_r, 1'b0};
    end else if (sel_fa) begin
      rdata_nxt = (fifo_r[0].cnt != 2'h0) ? {6'h00, fifo_r[0].m0} : 16'h0000;
    end else if (sel_fb) begin
      rdata_nxt = (fifo_r[1].cnt != 2'h0) ? {6'h00, fifo_r[1].m0} : 16'h0000;
    end else if (sel_st) begin
      rdata_nxt = {13'h0000, stat_r};
    end else if (sel_mk) begin
      rdata_nxt = {13'h0000, mask_r};
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_r <= '0;
    end else if (i_ce) begin
      rdata_r <= i_rd ? rdata_nxt : 16'h0000;
    end
  end

  assign o_rdata      = rdata_r;
  assign o_core       = core_r;
  assign o_periph_irq = irq_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn || !i_ce);

  sequence s_a_done; (state_r == ST_CONV_A) && core_done && !restart; endsequence
  sequence s_b_started; (state_r == ST_CONV_B) && core_r.start; endsequence

  property p_pseudo_pair; s_a_done |=> s_b_started; endproperty
  a_pseudo_pair: assert property (p_pseudo_pair) else $error("second conversion missing"); // R9
  property p_latch; s_a_done |=> push_a_r && (res_r == $past(i_core.result)); endproperty
  a_latch: assert property (p_latch) else $error("result not latched on done"); // R15
  property p_push_a; push_a_r && !pop_a && (fifo_r[0].cnt != FIFO_FULL)
    |=> fifo_r[0].cnt == $past(fifo_r[0].cnt) + 2'h1; endproperty
  a_push_a: assert property (p_push_a) else $error("result missed its own FIFO"); // R12
  property p_depth; (fifo_r[0].cnt <= FIFO_FULL) && (fifo_r[1].cnt <= FIFO_FULL); endproperty
  a_depth: assert property (p_depth) else $error("FIFO depth exceeded"); // R3
  property p_overflow; push_a_r && !pop_a && (fifo_r[0].cnt == FIFO_FULL) |=> stat_r[IRQ_OVF]
    && (fifo_r[0].m1 == $past(res_r)) && (fifo_r[0].cnt == FIFO_FULL); endproperty
  a_overflow: assert property (p_overflow) else $error("oldest entry not dropped"); // R4
  property p_start; (state_r == ST_IDLE) && trig |=> core_r.start ##1 !core_r.start; endproperty
  a_start: assert property (p_start) else $error("start pulse missing or long"); // R5
  property p_defer; busy && trig && !ctrl1_r.immediate && !pair_go |=> pend_r; endproperty
  a_defer: assert property (p_defer) else $error("deferred request lost"); // R7
  property p_shadow; (state_r == ST_CONV_A) && !restart |=> act_r == $past(act_r); endproperty
  a_shadow: assert property (p_shadow) else $error("working copy changed mid run"); // R13
  property p_cont; pair_end && cfg.continuous |=> (state_r == ST_GAP); endproperty
  a_cont: assert property (p_cont) else $error("continuous mode skipped the gap"); // R1
  property p_period; (state_r == ST_GAP) && cfg.continuous && !restart && !gap_done
    |=> (state_r == ST_GAP); endproperty
  a_period: assert property (p_period) else $error("pair started early"); // R2
  property p_eoc_irq; pair_end && !cfg.continuous && mask_r[IRQ_EOC] && !wr_mk && !wr_st
    |=> stat_r[IRQ_EOC] ##1 irq_r; endproperty
  a_eoc_irq: assert property (p_eoc_irq) else $error("end of pair raised no interrupt"); // R8
  property p_timeout; tmo_hit |=> (state_r == ST_IDLE) && stat_r[IRQ_TMO]; endproperty
  a_timeout: assert property (p_timeout) else $error("stalled conversion not aborted"); // R14
endmodule : dual_result_conversion_sequencer

/* File: test/conv_core_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Converter core stand-in
// ----------------------------------------
module conv_core_model (
  // Clock and reset
  input  wire logic                    i_mclk,
  input  wire logic                    i_rstn,
  // Request from sequencer
  input  wire conv_seq_pkg::core_req_t i_req,
  // Test controls
  input  wire logic [7:0]              i_delay,
  input  wire logic                    i_mute,
  input  wire logic [6:0]              i_tag,
  // Answer to sequencer
  output conv_seq_pkg::core_rsp_t      o_rsp
);
  import conv_seq_pkg::*;
  logic                 busy_r;
  logic [7:0]           cnt_r;
  logic [CHAN_W-1:0]    chan_r;
  logic                 done_r;
  logic [RES_W-1:0]     res_r;

  // Code carries the channel so misrouting shows up
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_r <= 1'b0;
      cnt_r  <= 8'h00;
      chan_r <= 3'h0;
      done_r <= 1'b0;
      res_r  <= 10'h000;
    end else begin
      done_r <= 1'b0;
      if (i_req.start) begin
        busy_r <= 1'b1;
        cnt_r  <= i_delay;
        chan_r <= i_req.chan;
      end else if (busy_r && cnt_r <= 8'h01 && !i_mute) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
        res_r  <= {chan_r, i_tag};
      end else if (busy_r && (cnt_r != 8'h00)) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  // Result only meaningful with done; inverted otherwise
  assign o_rsp.done   = done_r;
  assign o_rsp.result = done_r ? res_r : ~res_r;
endmodule : conv_core_model

/* File: test/dual_result_conversion_sequencer_test.sv */
`timescale 1ns/1ps
module dual_result_conversion_sequencer_test;
  import conv_seq_pkg::*;
  logic                 i_mclk, i_rstn, wr_s, rd_s, pin, trig, mute;
  logic [15:0]          addr, wdata, rdata, d;
  logic [7:0]           dly;
  logic [6:0]           tag;
  logic                 irq;
  core_req_t            req;
  core_rsp_t            rsp;
  int                   mismatches, num_checks, cyc, n0;
  int                   starts[$];
  logic [2:0]           chans[$];

  // ----------------------------------------
  // Clock, instances, start monitor
  // ----------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  dual_result_conversion_sequencer u_dual_result_conversion_sequencer (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_ext_start_pin(pin),
    .i_timer_trig(trig), .o_core(req), .i_core(rsp), .o_periph_irq(irq));
  conv_core_model u_conv_core_model (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(req), .i_delay(dly), .i_mute(mute),
    .i_tag(tag), .o_rsp(rsp));
  // Record when and where each conversion starts
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (req.start === 1'b1) begin
      starts.push_back(cyc);
      chans.push_back(req.chan);
    end
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge i_mclk);
    addr  <= a;
    wdata <= v;
    wr_s  <= 1'b1;
    @(posedge i_mclk);
    wr_s  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge i_mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge i_mclk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    rd(a);
    chk(d, exp);
  endtask : rchk
  // Poll busy under a bound; a stuck sequencer counts as a mismatch
  task automatic wait_idle();
    int n;
    repeat (3) @(posedge i_mclk);
    for (n = 0; n < 200; n++) begin
      rd(OFS_CTRL2);
      if (d[3] === 1'b0) break;
    end
    if (n == 200) chk(d, 16'h0000);
  endtask : wait_idle
  task automatic flush();
    repeat (2) rd(OFS_FIFO_A);
    repeat (2) rd(OFS_FIFO_B);
    wr(OFS_IRQ_STAT, 16'h0007);
  endtask : flush
  task automatic sw_pair(input logic [6:0] t);
    tag = t;
    wr(OFS_CTRL2, 16'h0001);
    wait_idle();
  endtask : sw_pair
  function automatic logic [15:0] c1(input logic [2:0] a, input logic [2:0] b,
                                     input logic cont, input logic imm);
    c1 = {8'h00, imm, cont, b, a};
  endfunction : c1
  task automatic complete_run();
    $display("mismatches=%0d num_checks=%0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #200us;
    mismatches++;
    complete_run();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {i_rstn, wr_s, rd_s, pin, trig, mute, addr, wdata} = '0;
    {mismatches, num_checks, cyc} = '0;
    dly = 8'h0a;
    tag = 7'h00;
    repeat (8) @(posedge i_mclk);
    i_rstn <= 1'b1;
    // Reset values, read-only and unmapped places
    rchk(OFS_CTRL1, CTRL1_RST);
    rchk(OFS_CTRL2, 16'h0000);
    rchk(OFS_IRQ_STAT, 16'h0000);
    rchk(OFS_IRQ_MASK, {13'h0, MASK_RST});
    rchk(OFS_FIFO_A, 16'h0000);
    chk({15'h0, req.clk_en}, 16'h0001);
    wr(16'h7040, 16'hffff);
    rchk(16'h7040, 16'h0000);
    wr(OFS_CTRL1, 16'hffff);
    rchk(OFS_CTRL1, CTRL1_WMASK);
    // One request gives an A then B result, routed by channel
    wr(OFS_CTRL1, c1(3'h3, 3'h5, 1'b0, 1'b0));
    wr(OFS_FIFO_A, 16'h0155);
    sw_pair(7'h11);
    rchk(OFS_FIFO_A, {6'h0, 3'h3, 7'h11});
    rchk(OFS_FIFO_B, {6'h0, 3'h5, 7'h11});
    // End flag, mask and clear
    rchk(OFS_IRQ_STAT, 16'h0001);
    chk({15'h0, irq}, 16'h0000);
    wr(OFS_IRQ_MASK, 16'h0001);
    repeat (2) @(posedge i_mclk);
    chk({15'h0, irq}, 16'h0001);
    wr(OFS_IRQ_STAT, 16'h0001);
    repeat (2) @(posedge i_mclk);
    chk({15'h0, irq}, 16'h0000);
    // Third push drops the oldest entry
    sw_pair(7'h21);
    sw_pair(7'h22);
    sw_pair(7'h23);
    rd(OFS_CTRL2);
    chk({12'h0, d[7:4]}, {12'h0, FIFO_FULL, FIFO_FULL});
    rchk(OFS_IRQ_STAT, 16'h0003);
    rchk(OFS_FIFO_A, {6'h0, 3'h3, 7'h22});
    rchk(OFS_FIFO_A, {6'h0, 3'h3, 7'h23});
    rchk(OFS_FIFO_A, 16'h0000);
    // Pin transitions both ways, then a timer event
    flush();
    wr(OFS_CTRL2, 16'h0002);
    pin <= 1'b1;
    wait_idle();
    pin <= 1'b0;
    wait_idle();
    rd(OFS_CTRL2);
    chk({12'h0, d[7:4]}, 16'h000a);
    flush();
    wr(OFS_CTRL2, 16'h0004);
    @(posedge i_mclk);
    trig <= 1'b1;
    @(posedge i_mclk);
    trig <= 1'b0;
    wait_idle();
    rd(OFS_CTRL2);
    chk({12'h0, d[7:4]}, 16'h0005);
    wr(OFS_CTRL2, 16'h0000);
    // Continuous pairs repeat unasked at the pair period
    flush();
    n0 = starts.size();
    wr(OFS_CTRL1, c1(3'h1, 3'h2, 1'b1, 1'b0));
    wr(OFS_CTRL2, 16'h0001);
    repeat (600) @(posedge i_mclk);
    wr(OFS_CTRL1, c1(3'h1, 3'h2, 1'b0, 1'b0));
    wait_idle();
    chk(16'(starts.size() - n0 >= 6), 16'h0001);
    chk(16'(starts[n0 + 2] - starts[n0]), 16'(PAIR_CYC));
    chk(16'(starts[n0 + 4] - starts[n0 + 2]), 16'(PAIR_CYC));
    rd(OFS_IRQ_STAT);
    chk({15'h0, d[0]}, 16'h0000);
    // Missing answer aborts after the limit
    flush();
    mute = 1'b1;
    wr(OFS_CTRL2, 16'h0001);
    repeat (88) @(posedge i_mclk);
    rchk(OFS_IRQ_STAT, 16'h0000);
    wait_idle();
    rchk(OFS_IRQ_STAT, 16'h0004);
    mute = 1'b0;
    // Mid-pair control write waits for the pair to end
    flush();
    dly = 8'h3c;
    sw_pair(7'h30);
    wr(OFS_CTRL2, 16'h0001);
    repeat (10) @(posedge i_mclk);
    wr(OFS_CTRL1, c1(3'h6, 3'h7, 1'b0, 1'b0));
    wait_idle();
    chk({13'h0, chans[chans.size() - 1]}, 16'h0002);
    sw_pair(7'h31);
    chk({13'h0, chans[chans.size() - 2]}, 16'h0006);
    chk({13'h0, chans[chans.size() - 1]}, 16'h0007);
    // Second request while busy: queued, then restart
    flush();
    wr(OFS_CTRL2, 16'h0001);
    wr(OFS_CTRL2, 16'h0001);
    wait_idle();
    rd(OFS_CTRL2);
    chk({12'h0, d[7:4]}, 16'h000a);
    flush();
    wr(OFS_CTRL1, c1(3'h6, 3'h7, 1'b0, 1'b1));
    wr(OFS_CTRL2, 16'h0001);
    wr(OFS_CTRL2, 16'h0001);
    wait_idle();
    rd(OFS_CTRL2);
    chk({12'h0, d[7:4]}, 16'h0005);
    complete_run();
  end
endmodule : dual_result_conversion_sequencer_test
